/* upgrade_watchdog_shift_interface.sv */
// How it works
// - Watchdog counts down from control preset
// - Watchdog counter is 29 bits
// - Start value is preset then 17 zeros
// - Decrement once per 10 MHz oscillator tick
// - Counting starts only in application user mode
// - Reload request falling edge restores initial count
// - Expiry flags status and reconfigures from factory
// - Disabled in factory and during configuration
// - Reload honoured only in remote application
// - Other signals work in every mode
// - Update writes only in remote factory
// - Reconfig request rise copies update to control
// - Shift logic acts on shift clock rises
// - Shift select high shifts left each rise
// - Both selects low load update from shift
// - Capture loads status plus control or update
// - Local mode update load has no effect
// - Status holds five reconfiguration cause flags
`timescale 1ns/1ns
`default_nettype none
module upgrade_watchdog_shift_interface
   import upgrade_pkg::*;
#(
   parameter int DIV = OSC_DIV
) (
   // Clock, reset, enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // User logic link, asynchronous to hclk
   input  wire logic        upgrade_shift_clock,
   input  wire shift_ctl_t  shift_ctl,
   input  wire logic        timer_reload_request_n,
   input  wire logic        logic_reconfig_request_n,
   output logic             shift_serial_out,
   // Configuration engine handshakes
   output logic             reconfig_pulse,
   output logic             factory_reconfig_pulse
);

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   localparam int NS = 6;
   logic [NS-1:0] s_lvl, s_rise, s_fall;
   logic          sclk_rise;
   logic          reload_fall;
   logic          reconfig_rise;
   shift_ctl_t    ctl;

   edge_sync #(.W(NS)) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .ce       (ce),
      // Active-low requests enter inverted so the reset level matches idle: no false edge
      .async_in ({upgrade_shift_clock, shift_ctl, ~timer_reload_request_n,
                  ~logic_reconfig_request_n}),
      .sync_out (s_lvl),
      .rise     (s_rise),
      .fall     (s_fall)
   );

   assign sclk_rise     = s_rise[5];
   assign ctl           = s_lvl[4:2];
   assign reload_fall   = s_rise[1];
   assign reconfig_rise = s_fall[0];

   // ---------------------------------------------------------------
   // Mode and registers
   // ---------------------------------------------------------------
   logic [2:0]          mode;
   logic                remote_mode, app_config, user_mode;
   logic [CTRL_W-1:0]   control;
   logic [CTRL_W-1:0]   update;
   logic [STATUS_W-1:0] status;
   logic [SHIFT_W-1:0]  shreg;
   logic [WDOG_W-1:0]   wdog;
   logic [WDOG_W-1:0]   wdog_start;
   logic                wdog_run;
   logic                wdog_expire;
   logic                osc_tick;
   logic [7:0]          osc_cnt;
   shift_op_t           op;

   assign remote_mode = mode[MODE_REMOTE_BIT];
   assign app_config  = mode[MODE_APP_BIT];
   assign user_mode   = mode[MODE_USER_BIT];

   // ---------------------------------------------------------------
   // Bus slave: zero wait state, always OKAY
   // ---------------------------------------------------------------
   logic       dph_wr, dph_rd;
   logic [7:0] dph_addr;
   logic       wr_mode, wr_ctrl, wr_factory;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr   <= 1'b0;
         dph_rd   <= 1'b0;
         dph_addr <= 8'h00;
      end else if (ce && hready) begin
         dph_wr   <= hsel && htrans[1] && hwrite;
         dph_rd   <= hsel && htrans[1] && !hwrite;
         dph_addr <= haddr[7:0];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wr_mode    = ce && dph_wr && dph_addr == ADDR_MODE;
   assign wr_ctrl    = ce && dph_wr && dph_addr == ADDR_CONTROL;
   assign wr_factory = ce && dph_wr && dph_addr == ADDR_FACTORY;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (ce && hready && hsel && htrans[1] && !hwrite) begin
         unique case (haddr[7:0])
            ADDR_MODE:    hrdata <= {29'h0, mode};
            ADDR_STATUS:  hrdata <= {27'h0, status};
            ADDR_CONTROL: hrdata <= {8'h00, control};
            ADDR_UPDATE:  hrdata <= {8'h00, update};
            ADDR_WDOG:    hrdata <= {3'h0, wdog};
            default:      hrdata <= 32'h00000000;
         endcase
      end
   end

   // Configuration state as reported by the configuration engine
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode <= MODE_RESET;
      end else if (ce) begin
         if (wdog_expire || reconfig_rise) begin
            mode[MODE_USER_BIT] <= 1'b0;
         end else if (wr_mode) begin
            mode <= hwdata[2:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Shift interface
   // ---------------------------------------------------------------
   always_comb begin
      if (!sclk_rise) begin
         op = SH_HOLD;
      end else if (ctl.shift_not_load_select) begin
         op = SH_SHIFT;
      end else if (ctl.capture_not_update_select) begin
         op = SH_CAPTURE;
      end else begin
         op = SH_UPDATE;
      end
   end

   // Shifts/captures run in any mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shreg <= '0;
      end else if (ce) begin
         unique case (op)
            SH_SHIFT:   shreg <= {shreg[SHIFT_W-2:0], ctl.shift_serial_in};
            SH_CAPTURE: shreg <= {status, app_config ? control : update};
            default:    shreg <= shreg;
         endcase
      end
   end

   assign shift_serial_out = shreg[SHIFT_W-1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         update <= CTRL_RESET;
      end else if (ce && op == SH_UPDATE && remote_mode && !app_config) begin
         update <= shreg[CTRL_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Control and status
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control <= CTRL_RESET;
      end else if (ce) begin
         if (wdog_expire) begin
            control <= CTRL_RESET;
         end else if (reconfig_rise) begin
            control <= update;
         end else if (wr_ctrl) begin
            control <= hwdata[CTRL_W-1:0];
         end
      end
   end

   // Hardware set wins over software clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status <= STATUS_RESET;
      end else if (ce) begin
         status <= (wr_factory ? status & ~hwdata[STATUS_W-1:0] : status)
                   | (STATUS_W'(wdog_expire) << ST_WDOG_BIT)
                   | (STATUS_W'(reconfig_rise) << ST_CORE_BIT);
      end
   end

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   assign wdog_start = {control[CTRL_PRESET_LSB +: PRESET_W],
                        {LOW_ZERO_W{1'b0}}};
   assign wdog_run   = user_mode && app_config && remote_mode
                       && control[CTRL_WDEN_BIT];
   assign osc_tick   = osc_cnt == 8'(DIV - 1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_cnt <= 8'h00;
      end else if (ce) begin
         osc_cnt <= osc_tick ? 8'h00 : osc_cnt + 8'h01;
      end
   end

   assign wdog_expire = ce && wdog_run && osc_tick && wdog == '0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdog <= '0;
      end else if (ce) begin
         if (!wdog_run || reload_fall) begin
            wdog <= wdog_start;
         end else if (osc_tick && wdog != '0) begin
            wdog <= wdog - WDOG_W'(1);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reconfig_pulse         <= 1'b0;
         factory_reconfig_pulse <= 1'b0;
      end else if (ce) begin
         reconfig_pulse         <= reconfig_rise;
         factory_reconfig_pulse <= wdog_expire;
      end
   end

endmodule
`default_nettype wire

/* upgrade_pkg.sv */
package upgrade_pkg;

   // ---------------------------------------------------------------
   // Register layout
   // ---------------------------------------------------------------
   localparam int PRESET_W    = 12;
   localparam int WDOG_W      = 29;
   localparam int LOW_ZERO_W  = 17;
   localparam int STATUS_W    = 5;
   localparam int CTRL_W      = 24;
   localparam int SHIFT_W     = STATUS_W + CTRL_W;

   // Control/update word fields
   localparam int CTRL_ANF_BIT      = 0;
   localparam int CTRL_WDEN_BIT     = 11;
   localparam int CTRL_PRESET_LSB   = 12;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 24'h000000;

   // Status bits
   localparam int ST_CRC_BIT   = 0;
   localparam int ST_NSTAT_BIT = 1;
   localparam int ST_CORE_BIT  = 2;
   localparam int ST_NCFG_BIT  = 3;
   localparam int ST_WDOG_BIT  = 4;
   localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h00;

   // ---------------------------------------------------------------
   // AHB-Lite map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_MODE    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_CONTROL = 8'h08;
   localparam logic [7:0] ADDR_UPDATE  = 8'h0C;
   localparam logic [7:0] ADDR_WDOG    = 8'h10;
   localparam logic [7:0] ADDR_FACTORY = 8'h14;
   localparam int MODE_REMOTE_BIT = 0;
   localparam int MODE_APP_BIT    = 1;
   localparam int MODE_USER_BIT   = 2;
   localparam logic [2:0] MODE_RESET = 3'h0;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int HCLK_MHZ = 250;
   localparam int OSC_MHZ  = 10;
   localparam int OSC_DIV  = HCLK_MHZ / OSC_MHZ;

   typedef struct packed {
      logic shift_not_load_select;
      logic capture_not_update_select;
      logic shift_serial_in;
   } shift_ctl_t;

   typedef enum logic [1:0] {
      SH_SHIFT,
      SH_CAPTURE,
      SH_UPDATE,
      SH_HOLD
   } shift_op_t;

endpackage

/* edge_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module edge_sync
   import upgrade_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         ce,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] meta;
   logic [W-1:0] last;

   // Two flops before use; meta feeds only sync_out
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta     <= '0;
         sync_out <= '0;
         last     <= '0;
      end else if (ce) begin
         meta     <= async_in;
         sync_out <= meta;
         last     <= sync_out;
      end
   end

   assign rise = sync_out & ~last;
   assign fall = ~sync_out & last;
endmodule
`default_nettype wire

/* upgrade_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module upgrade_assertions (
   // Bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Link
   input wire logic        upgrade_shift_clock,
   input wire logic        logic_reconfig_request_n,
   input wire logic        shift_serial_out,
   input wire logic        reconfig_pulse,
   input wire logic        factory_reconfig_pulse
);
   logic       clk_d;
   logic       cfg_d;
   logic [3:0] since_clk;
   logic [3:0] since_cfg;
   // Ages saturate so a long idle spell never wraps into a false cause
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_d     <= 1'b0;
         cfg_d     <= 1'b1;
         since_clk <= 4'hF;
         since_cfg <= 4'hF;
      end else begin
         clk_d     <= upgrade_shift_clock;
         cfg_d     <= logic_reconfig_request_n;
         since_clk <= (upgrade_shift_clock && !clk_d) ? 4'h0 : since_clk + 4'(since_clk != 4'hF);
         since_cfg <= (logic_reconfig_request_n && !cfg_d) ? 4'h0 : since_cfg + 4'(since_cfg != 4'hF);
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence shift_rise;
      $rose(upgrade_shift_clock);
   endsequence
   sequence cfg_rise;
      $rose(logic_reconfig_request_n);
   endsequence
   a_ready_high: assert property (hreadyout) else $error("hreadyout low");
   a_okay_only: assert property (!hresp) else $error("error response");
   a_rdata_hold: assert property ($changed(hrdata) |-> $past(hsel && htrans[1] && hready))
      else $error("hrdata changed without an accepted address");
   a_reconfig_follows: assert property (cfg_rise |-> ##[2:8] reconfig_pulse)
      else $error("no reconfig pulse after request rise");
   a_reconfig_cause: assert property (reconfig_pulse |-> since_cfg <= 4'h8)
      else $error("reconfig pulse without request");
   a_reconfig_single: assert property (reconfig_pulse |=> !reconfig_pulse)
      else $error("reconfig pulse too long");
   a_expiry_single: assert property (factory_reconfig_pulse |=> !factory_reconfig_pulse)
      else $error("expiry pulse too long");
   a_dout_cause: assert property ($changed(shift_serial_out) |-> since_clk <= 4'h8)
      else $error("serial out moved without a shift clock rise");
   a_dout_settle: assert property (shift_rise |-> ##7 $stable(shift_serial_out) [*3])
      else $error("serial out not settled after rise");
endmodule
bind upgrade_watchdog_shift_interface upgrade_assertions chk_u (
   .hclk, .hresetn, .hsel, .htrans, .hready, .hrdata, .hreadyout, .hresp, .upgrade_shift_clock,
   .logic_reconfig_request_n, .shift_serial_out, .reconfig_pulse, .factory_reconfig_pulse);
`default_nettype wire

/* user_logic_model.sv */
`timescale 1ns/1ns
`default_nettype none
module user_logic_model
   import upgrade_pkg::*;
(
   // Link toward the block
   output var logic       upgrade_shift_clock,
   output var shift_ctl_t shift_ctl,
   output var logic       timer_reload_request_n,
   output var logic       logic_reconfig_request_n,
   input  wire logic      shift_serial_out
);
   initial begin
      upgrade_shift_clock = 1'b0;
      shift_ctl = '{1'b0, 1'b1, 1'b0};
      timer_reload_request_n = 1'b1;
      logic_reconfig_request_n = 1'b1;
   end
   // Selects settle half a period before each rise; clock idles low between frames
   task automatic pulse(input logic sh, input logic cp);
      #3;
      shift_ctl.shift_not_load_select = sh;
      shift_ctl.capture_not_update_select = cp;
      #40 upgrade_shift_clock = 1'b1;
      #40 upgrade_shift_clock = 1'b0;
   endtask
   task automatic xfer(input logic [28:0] w, output logic [28:0] r);
      #3;
      for (int i = 28; i >= 0; i--) begin
         shift_ctl = '{1'b1, 1'b0, w[i]};
         #40 r[i] = shift_serial_out;
         upgrade_shift_clock = 1'b1;
         #40 upgrade_shift_clock = 1'b0;
      end
      // Released data line shows the inverse, never a stale copy
      shift_ctl.shift_serial_in = ~w[0];
   endtask
   task automatic reload();
      #3 timer_reload_request_n = 1'b0;
      #20 timer_reload_request_n = 1'b1;
   endtask
   task automatic reconfig();
      #3 logic_reconfig_request_n = 1'b0;
      #40 logic_reconfig_request_n = 1'b1;
   endtask
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import upgrade_pkg::*;
   localparam int DIVB = 2;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] seed = 32'h1D92;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, upgrade_shift_clock, timer_reload_request_n;
   logic        logic_reconfig_request_n, shift_serial_out, reconfig_pulse, factory_reconfig_pulse;
   shift_ctl_t  shift_ctl;
   int          mismatches = 0;
   int          n_checks = 0;
   int          cycles = 0;
   int          n_rc = 0;
   int          n_fr = 0;
   always #2 hclk = ~hclk;
   upgrade_watchdog_shift_interface #(.DIV(DIVB)) dut_u (
      .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .upgrade_shift_clock, .shift_ctl,
      .timer_reload_request_n, .logic_reconfig_request_n, .shift_serial_out, .reconfig_pulse,
      .factory_reconfig_pulse);
   user_logic_model ul (.upgrade_shift_clock, .shift_ctl, .timer_reload_request_n,
      .logic_reconfig_request_n, .shift_serial_out);
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge hclk) begin
      n_rc += int'(reconfig_pulse === 1'b1);
      n_fr += int'(factory_reconfig_pulse === 1'b1);
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check(r, exp);
   endtask
   initial begin
      logic [31:0] upd, ctl, st, c0, c1;
      logic [28:0] w, q;
      int          e, d;
      logic [7:0]  amap [5] = '{ADDR_MODE, ADDR_STATUS, ADDR_CONTROL, ADDR_UPDATE, 8'h20};
      logic [31:0] refused [3] = '{32'h0, 32'h2, 32'h3};
      logic [31:0] held [2] = '{32'h5, 32'h3};
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (amap[i]) rd(amap[i], 32'h0);
      wr(8'h20, 32'hFFFFFFFF);
      rd(8'h20, 32'h0);
      $display("test reset values done");
      wr(ADDR_MODE, 32'h1 << MODE_REMOTE_BIT);
      w = 29'(rnd());
      ul.xfer(w, q);
      ul.pulse(1'b0, 1'b0);
      upd = {8'h0, w[23:0]};
      rd(ADDR_UPDATE, upd);
      ul.pulse(1'b0, 1'b1);
      ul.xfer(29'(rnd()), q);
      check({3'h0, q}, upd);
      foreach (refused[i]) begin
         wr(ADDR_MODE, refused[i]);
         ul.xfer(29'(rnd()), q);
         ul.pulse(1'b0, 1'b0);
         rd(ADDR_UPDATE, upd);
      end
      $display("test shift path done");
      wr(ADDR_MODE, 32'h1);
      ul.reconfig();
      repeat (10) @(posedge hclk);
      ctl = upd;
      st = 32'h1 << ST_CORE_BIT;
      rd(ADDR_CONTROL, ctl);
      rd(ADDR_STATUS, st);
      check(n_rc, 32'h1);
      wr(ADDR_MODE, 32'h3);
      ul.pulse(1'b0, 1'b1);
      ul.xfer(29'(rnd()), q);
      check({3'h0, q}, {3'h0, st[4:0], ctl[23:0]});
      $display("test reconfig done");
      ctl = (32'hFFF << CTRL_PRESET_LSB) | (32'h1 << CTRL_WDEN_BIT);
      wr(ADDR_CONTROL, ctl);
      foreach (held[i]) begin
         wr(ADDR_MODE, held[i]);
         bus(1'b0, ADDR_WDOG, 32'h0, c0);
         ul.reload();
         repeat (20) @(posedge hclk);
         bus(1'b0, ADDR_WDOG, 32'h0, c1);
         check(c1, c0);
      end
      wr(ADDR_MODE, 32'h7);
      e = cycles;
      repeat (40) @(posedge hclk);
      bus(1'b0, ADDR_WDOG, 32'h0, c0);
      d = 32'h1FFE0000 - int'(c0) - (cycles - e) / DIVB;
      check(32'(d >= -4 && d <= 4), 32'h1);
      ul.reload();
      bus(1'b0, ADDR_WDOG, 32'h0, c1);
      d = 32'h1FFE0000 - int'(c1);
      check(32'(d >= 0 && d <= 8), 32'h1);
      wr(ADDR_CONTROL, 32'h1 << CTRL_WDEN_BIT);
      ul.reload();
      repeat (20) @(posedge hclk);
      rd(ADDR_STATUS, st | (32'h1 << ST_WDOG_BIT));
      rd(ADDR_CONTROL, 32'h0);
      rd(ADDR_MODE, 32'h3);
      check(n_fr, 32'h1);
      wr(ADDR_FACTORY, 32'h1F);
      rd(ADDR_STATUS, 32'h0);
      $display("test watchdog done");
      print_verdict();
   end
endmodule
`default_nettype wire
